// [hw/memmap_pkg.sv]
package memmap_pkg;

  // ==========================================================
  // Address map
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_W       = 8;
  localparam int          OFFS_W       = 16;
  localparam int          EXT_ADDR_W   = 22;
  localparam int          IO_ADDR_W    = 18;
  localparam int          IO_OFFS_W    = 10;
  localparam int          ROM_W        = 10;
  localparam int          NUM_BANKS    = 4;
  localparam logic [7:0]  PAGE_SRAM    = 8'h00;
  localparam logic [7:0]  PAGE_BOOT    = 8'hFF;
  localparam logic [7:0]  IO_PAGE_LAST_INT = 8'h07;
  localparam logic [15:0] ROM_LIMIT    = 16'h0400;

  // ==========================================================
  // Reset bank boundaries: first page of banks 1..3
  localparam logic [7:0]  BANK1_START_RST = 8'h40;
  localparam logic [7:0]  BANK2_START_RST = 8'h80;
  localparam logic [7:0]  BANK3_START_RST = 8'hC0;
  localparam logic [3:0]  WAIT_RST        = 4'hF;

  // ==========================================================
  // Register port map (word offsets)
  localparam logic [3:0]  REG_PORT_CFG  = 4'h0;
  localparam logic [3:0]  REG_BANK_BND  = 4'h1;
  localparam logic [3:0]  REG_BANK_WAIT = 4'h2;
  localparam logic [3:0]  REG_FLAG_OUT  = 4'h3;
  localparam logic [3:0]  REG_FLAG_OE   = 4'h4;
  localparam logic [3:0]  REG_FLAG_IN   = 4'h5;
  localparam logic [3:0]  REG_STATUS    = 4'h6;
  localparam int          CFG_WIDE_BIT  = 0;
  localparam int          CFG_PACK24_BIT = 1;

  // Requesters, index is priority (0 highest)
  localparam int          NUM_REQ  = 3;
  localparam int          REQ_DMA  = 0;
  localparam int          REQ_DM   = 1;
  localparam int          REQ_PM   = 2;

  typedef enum logic [1:0] {
    TGT_SRAM,
    TGT_ROM,
    TGT_EXT,
    TGT_IO
  } target_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        io;
    logic [23:0] addr;
    logic [23:0] wdata;
  } req_s;

  typedef struct packed {
    logic        done;
    logic [23:0] rdata;
  } rsp_s;

  typedef struct packed {
    logic        sram;
    logic        rom;
    logic        iocfg;
    logic        write;
    logic [15:0] addr;
    logic [23:0] wdata;
  } int_req_s;

endpackage : memmap_pkg

// [hw/memmap_decoder.sv]
`timescale 1ns/1ps
module memmap_decoder
  import memmap_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_b_in,
  // Requesters
  input  wire req_s [NUM_REQ-1:0]    req_in,
  input  wire logic [7:0]            io_page_value_in,
  input  wire logic                  boot_ext_in,
  output logic      [NUM_REQ-1:0]    grant_out,
  output rsp_s      [NUM_REQ-1:0]    rsp_out,
  // Internal targets
  output int_req_s                   int_req_out,
  input  wire logic [23:0]           int_rdata_in,
  // External port
  output logic [EXT_ADDR_W-1:0]      ext_addr_out,
  input  wire logic [15:0]           ext_data_in,
  output logic [15:0]                ext_data_out,
  output logic [15:0]                ext_data_oe_out,
  output logic [NUM_BANKS-1:0]       bank_select_n_out,
  output logic                       io_space_select_n_out,
  output logic                       boot_space_select_n_out,
  output logic                       ext_rd_n_out,
  output logic                       ext_wr_n_out,
  output logic [7:0]                 flag_in_out,
  // Register port
  input  wire logic [3:0]            reg_addr_in,
  input  wire logic [15:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [15:0]                reg_rdata_out
);

  // ==========================================================
  // Configuration registers
  logic [1:0]                    cfg_q;
  logic [NUM_BANKS-2:0][7:0]     bnd_q;
  logic [NUM_BANKS-1:0][WAIT_W-1:0] wait_q;
  logic [7:0]                    flag_o_q;
  logic [7:0]                    flag_oe_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cfg_q  <= 2'h0;
      bnd_q  <= {BANK3_START_RST, BANK2_START_RST, BANK1_START_RST};
      wait_q <= {NUM_BANKS{WAIT_RST[WAIT_W-1:0]}};
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_PORT_CFG:  cfg_q <= reg_wdata_in[1:0];
        REG_BANK_BND:  bnd_q[0] <= reg_wdata_in[7:0];
        REG_BANK_WAIT: wait_q <= reg_wdata_in[NUM_BANKS*WAIT_W-1:0];
        default: begin
        end
      endcase
      // Bank 2 start shares one 16-bit word with bank 1 start
      if (reg_addr_in == REG_BANK_BND) begin
        bnd_q[1] <= reg_wdata_in[15:8];
      end
      // Bank 3 start shares the flag-out word, upper byte
      if (reg_addr_in == REG_FLAG_OUT) begin
        bnd_q[2] <= reg_wdata_in[15:8];
      end
    end
  end

  // Spare upper data lines as flags in 8-bit mode
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      flag_o_q  <= 8'h00;
      flag_oe_q <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_FLAG_OUT) begin
        flag_o_q <= reg_wdata_in[7:0];
      end
      if (reg_addr_in == REG_FLAG_OE) begin
        flag_oe_q <= reg_wdata_in[7:0];
      end
    end
  end

  // ==========================================================
  // Arbiter and transfer sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXT,
    ST_LAST,
    ST_DONE
  } state_e;

  state_e                      state_q;
  logic [1:0]                  who_q;
  req_s                        cur_q;
  logic [1:0]                  beat_q;
  logic [1:0]                  beats_q;
  logic [WAIT_W-1:0]           wcnt_q;
  logic [23:0]                 asm_q;
  logic [1:0]                  sel_kind_q;
  logic [1:0]                  bank_q;
  logic                        smp_q;
  logic [1:0]                  smp_beat_q;

  logic [1:0]                  pick;
  logic                        any_req;
  always_comb begin
    pick    = 2'd0;
    any_req = 1'b0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      // Skip a requester whose grant is in flight: it drops valid a cycle late
      if (req_in[i].valid && !grant_out[i]) begin
        pick    = 2'(i);
        any_req = 1'b1;
      end
    end
  end

  req_s       sel;
  logic [7:0] pg;
  target_e    tgt;
  logic [1:0] bank;
  logic [EXT_ADDR_W-1:0] phys;
  assign sel = req_in[pick];
  assign pg  = sel.addr[23:16];

  always_comb begin
    if (sel.io) begin
      tgt = (sel.addr[17:10] <= IO_PAGE_LAST_INT) ? TGT_IO : TGT_EXT;
    end else if (pg == PAGE_SRAM) begin
      tgt = TGT_SRAM;
    end else if (pg == PAGE_BOOT && sel.addr[15:0] < ROM_LIMIT && !boot_ext_in) begin
      tgt = TGT_ROM;
    end else begin
      tgt = TGT_EXT;
    end
    if (pg >= bnd_q[2])        bank = 2'd3;
    else if (pg >= bnd_q[1])   bank = 2'd2;
    else if (pg >= bnd_q[0])   bank = 2'd1;
    else                       bank = 2'd0;
    phys = sel.io ? EXT_ADDR_W'({io_page_value_in, sel.addr[9:0]})
                  : sel.addr[EXT_ADDR_W-1:0];
  end

  logic       ext_go;
  assign ext_go = (state_q == ST_IDLE) && any_req && (tgt == TGT_EXT);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_q    <= ST_IDLE;
      who_q      <= 2'd0;
      cur_q      <= '0;
      beat_q     <= 2'd0;
      beats_q    <= 2'd0;
      wcnt_q     <= '0;
      asm_q      <= 24'h000000;
      sel_kind_q <= 2'd0;
      bank_q     <= 2'd0;
      smp_q      <= 1'b0;
      smp_beat_q <= 2'd0;
    end else begin
      // Pins lag the sequencer by one flop, so data is taken a cycle later
      smp_q      <= (state_q == ST_EXT) && (wcnt_q == '0);
      smp_beat_q <= beat_q;
      if (smp_q) begin
        if (cfg_q[CFG_WIDE_BIT]) begin
          asm_q <= smp_beat_q == 2'd0 ? {8'h00, ext_data_in}
                                      : {ext_data_in[7:0], asm_q[15:0]};
        end else begin
          asm_q[8*smp_beat_q +: 8] <= ext_data_in[7:0];
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (ext_go) begin
            state_q <= ST_EXT;
            who_q   <= pick;
            cur_q   <= sel;
            cur_q.addr <= 24'(phys);
            beat_q  <= 2'd0;
            // Last beat index (beats minus one) from width and word size
            beats_q <= cfg_q[CFG_WIDE_BIT] ? (cfg_q[CFG_PACK24_BIT] ? 2'd1 : 2'd0)
                                           : (cfg_q[CFG_PACK24_BIT] ? 2'd2 : 2'd1);
            wcnt_q  <= wait_q[bank];
            asm_q   <= 24'h000000;
            sel_kind_q <= sel.io ? 2'd1 : (pg == PAGE_BOOT ? 2'd2 : 2'd0);
            bank_q  <= bank;
          end
        end
        ST_EXT: begin
          if (wcnt_q != '0) begin
            wcnt_q <= wcnt_q - 1'b1;
          end else begin
            if (beat_q == beats_q) begin
              state_q <= ST_LAST;
            end else begin
              beat_q <= beat_q + 2'd1;
              wcnt_q <= wait_q[bank_q];
            end
          end
        end
        ST_LAST: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // External pins, all registered
  logic       in_ext;
  logic [4:0] shamt;
  assign in_ext = (state_q == ST_EXT);
  assign shamt  = cfg_q[CFG_WIDE_BIT] ? 5'(beat_q) << 4 : 5'(beat_q) << 3;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ext_addr_out            <= '0;
      ext_data_out            <= 16'h0000;
      ext_data_oe_out         <= 16'h0000;
      bank_select_n_out       <= 4'hF;
      io_space_select_n_out   <= 1'b1;
      boot_space_select_n_out <= 1'b1;
      ext_rd_n_out            <= 1'b1;
      ext_wr_n_out            <= 1'b1;
      flag_in_out             <= 8'h00;
    end else begin
      ext_addr_out <= cur_q.addr[EXT_ADDR_W-1:0] + EXT_ADDR_W'(beat_q);
      ext_data_out[7:0] <= 8'(cur_q.wdata >> shamt);
      ext_data_out[15:8] <= cfg_q[CFG_WIDE_BIT] ? 8'(cur_q.wdata >> (shamt + 5'd8))
                                                : flag_o_q;
      ext_data_oe_out[7:0]  <= {8{in_ext && cur_q.write}};
      ext_data_oe_out[15:8] <= cfg_q[CFG_WIDE_BIT] ? {8{in_ext && cur_q.write}}
                                                   : flag_oe_q;
      bank_select_n_out     <= ~(4'(in_ext && sel_kind_q == 2'd0) << bank_q);
      io_space_select_n_out <= ~(in_ext && sel_kind_q == 2'd1);
      boot_space_select_n_out <= ~(in_ext && sel_kind_q == 2'd2);
      ext_rd_n_out <= ~(in_ext && !cur_q.write);
      ext_wr_n_out <= ~(in_ext && cur_q.write);
      flag_in_out  <= cfg_q[CFG_WIDE_BIT] ? 8'h00 : ext_data_in[15:8];
    end
  end

  // ==========================================================
  // Internal path: one-cycle request strobe, no done or read data back, no external cycle
  logic int_go;
  assign int_go = (state_q == ST_IDLE) && any_req && (tgt != TGT_EXT);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      int_req_out <= '0;
      grant_out   <= '0;
      rsp_out     <= '0;
    end else begin
      int_req_out.sram  <= int_go && tgt == TGT_SRAM;
      int_req_out.rom   <= int_go && tgt == TGT_ROM;
      int_req_out.iocfg <= int_go && tgt == TGT_IO;
      int_req_out.write <= sel.write;
      int_req_out.addr  <= sel.addr[15:0];
      int_req_out.wdata <= sel.wdata;
      grant_out <= (int_go || ext_go) ? NUM_REQ'(1) << pick : '0;
      for (int i = 0; i < NUM_REQ; i++) begin
        rsp_out[i].done  <= (state_q == ST_DONE && who_q == 2'(i));
        rsp_out[i].rdata <= asm_q;
      end
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_PORT_CFG:  reg_rdata_out <= {14'h0000, cfg_q};
        REG_BANK_BND:  reg_rdata_out <= {bnd_q[1], bnd_q[0]};
        REG_BANK_WAIT: reg_rdata_out <= 16'(wait_q);
        REG_FLAG_OUT:  reg_rdata_out <= {bnd_q[2], flag_o_q};
        REG_FLAG_OE:   reg_rdata_out <= {8'h00, flag_oe_q};
        REG_FLAG_IN:   reg_rdata_out <= {8'h00, flag_in_out};
        REG_STATUS:    reg_rdata_out <= {12'h000, bank_q, 1'b0, in_ext};
        default:       reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule : memmap_decoder

// [tb/memmap_checker.sv]
`timescale 1ns/1ps
module memmap_checker
  import memmap_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  // Watched ports
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  input  wire req_s [NUM_REQ-1:0]   req_in,
  input  wire logic                 boot_ext_in,
  input  wire logic [NUM_REQ-1:0]   grant_out,
  input  wire rsp_s [NUM_REQ-1:0]   rsp_out,
  input  wire int_req_s             int_req_out,
  input  wire logic [NUM_BANKS-1:0] bank_select_n_out,
  input  wire logic                 io_space_select_n_out,
  input  wire logic                 boot_space_select_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic [5:0] sel_on;
  assign sel_on = ~{bank_select_n_out, io_space_select_n_out, boot_space_select_n_out};
  sequence s_dma_take;
    grant_out[REQ_DMA] && !$past(req_in[REQ_DMA].io)
      && $past(req_in[REQ_DMA].addr[23:16]) != PAGE_SRAM
      && $past(req_in[REQ_DMA].addr[23:16]) != PAGE_BOOT;
  endsequence
  sequence s_any_done;
    rsp_out[0].done || rsp_out[1].done || rsp_out[2].done;
  endsequence
  property p_one_sel; $countones(sel_on) <= 1; endproperty
  property p_grant_one; $onehot0(grant_out); endproperty
  property p_int_quiet;
    (int_req_out.sram || int_req_out.rom || int_req_out.iocfg) |-> sel_on == 6'h00;
  endproperty
  property p_prio_dm;
    grant_out[REQ_DM] |-> !$past(req_in[REQ_DMA].valid && !grant_out[REQ_DMA]);
  endproperty
  property p_prio_pm;
    grant_out[REQ_PM] |-> !$past((req_in[REQ_DMA].valid && !grant_out[REQ_DMA])
                                 || (req_in[REQ_DM].valid && !grant_out[REQ_DM]));
  endproperty
  property p_sram;
    grant_out[REQ_DMA] && $past(req_in[REQ_DMA].addr[23:16] == PAGE_SRAM
                                && !req_in[REQ_DMA].io) |-> int_req_out.sram;
  endproperty
  property p_rom;
    grant_out[REQ_DMA] && $past(req_in[REQ_DMA].addr[23:10] == {PAGE_BOOT, 6'h00}
      && !req_in[REQ_DMA].io && !boot_ext_in) |-> int_req_out.rom;
  endproperty
  property p_iocfg;
    grant_out[REQ_DM] && $past(req_in[REQ_DM].io
      && req_in[REQ_DM].addr[17:10] <= IO_PAGE_LAST_INT)
      |-> int_req_out.iocfg ##1 io_space_select_n_out;
  endproperty
  property p_ext; s_dma_take |-> ##1 bank_select_n_out != 4'hF; endproperty
  property p_done; $fell(&bank_select_n_out) |-> ##[1:200] s_any_done; endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects active");
  a_grant_one: assert property (p_grant_one) else $error("two grants");
  a_int_quiet: assert property (p_int_quiet) else $error("select on internal");
  a_prio_dm: assert property (p_prio_dm) else $error("priority broken");
  a_prio_pm: assert property (p_prio_pm) else $error("priority broken");
  a_sram: assert property (p_sram) else $error("page 0 not to sram");
  a_rom: assert property (p_rom) else $error("boot rom missed");
  a_iocfg: assert property (p_iocfg) else $error("low io page left chip");
  a_ext: assert property (p_ext) else $error("no bank select");
  a_done: assert property (p_done) else $error("transfer never done");
endmodule : memmap_checker

bind memmap_decoder memmap_checker #(.WAIT_W(WAIT_W)) memmap_checker_inst (
  .clk_sys_in, .rst_b_in, .req_in, .boot_ext_in, .grant_out, .rsp_out, .int_req_out,
  .bank_select_n_out, .io_space_select_n_out, .boot_space_select_n_out);

// [tb/ext_sram_model.sv]
`timescale 1ns/1ps
module ext_sram_model (
  // Port pins
  input  wire logic        clk_sys_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [15:0] data_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  // Board straps
  input  wire logic        wide_in,
  input  wire logic [7:0]  flags_in,
  output logic      [15:0] data_out
);
  logic [15:0] mem_q [0:255];
  logic [15:0] last_q = 16'h0000;
  always_ff @(posedge clk_sys_in) begin
    if (!wr_n_in) mem_q[addr_in[7:0]] <= wide_in ? data_in : {8'h00, data_in[7:0]};
    if (!rd_n_in) last_q <= data_out;
  end
  // Released bus has no pull: show inverse of last word
  always_comb begin
    data_out = rd_n_in ? ~last_q : mem_q[addr_in[7:0]];
    if (!wide_in) data_out[15:8] = flags_in;
  end
endmodule : ext_sram_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import memmap_pkg::*;
  logic               clk_sys_in = 1'b0;
  logic               rst_b_in = 1'b0;
  req_s [NUM_REQ-1:0] req_in = '0;
  logic [7:0]         io_page_value_in = 8'h00;
  logic               boot_ext_in = 1'b0;
  logic [3:0]         reg_addr_in = 4'h0;
  logic [15:0]        reg_wdata_in = 16'h0000;
  logic               reg_wr_in = 1'b0;
  logic               reg_rd_in = 1'b0;
  logic               wide = 1'b0;
  logic [NUM_REQ-1:0] grant_out;
  rsp_s [NUM_REQ-1:0] rsp_out;
  int_req_s           int_req_out;
  logic [21:0]        ext_addr_out, io_addr;
  logic [15:0]        ext_data_out, ext_data_oe_out, pin_data, model_data, reg_rdata_out;
  logic [3:0]         bank_select_n_out;
  logic               io_space_select_n_out, boot_space_select_n_out, rd_n, wr_n;
  logic [7:0]         flag_in_out;
  logic [7:0]         pg [8] = '{8'h01, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFE};
  int                 mismatches = 0;
  int                 checks_done = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  // Pin level: whoever enables drives
  assign pin_data = (ext_data_oe_out & ext_data_out) | (~ext_data_oe_out & model_data);
  memmap_decoder memmap_decoder_inst (.clk_sys_in, .rst_b_in, .req_in, .io_page_value_in,
    .boot_ext_in, .grant_out, .rsp_out, .int_req_out, .int_rdata_in(24'h000000),
    .ext_addr_out, .ext_data_in(pin_data), .ext_data_out, .ext_data_oe_out,
    .bank_select_n_out, .io_space_select_n_out, .boot_space_select_n_out,
    .ext_rd_n_out(rd_n), .ext_wr_n_out(wr_n), .flag_in_out, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out);
  ext_sram_model ext_sram_model_inst (.clk_sys_in, .addr_in(ext_addr_out),
    .data_in(ext_data_out), .rd_n_in(rd_n), .wr_n_in(wr_n), .wide_in(wide),
    .flags_in(8'hA5), .data_out(model_data));
  // ==========================================================
  // Bus tasks
  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic reg_wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(logic [3:0] a, output logic [23:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_sys_in);
    d = {8'h00, reg_rdata_out};
  endtask : reg_rd
  task automatic access(int i, logic w, logic io, logic [23:0] a, logic [23:0] d, logic ext,
                        output logic [23:0] rd, output logic [5:0] s, output int_req_s ir);
    int n;
    s = 6'h3F;
    n = 0;
    @(posedge clk_sys_in);
    req_in[i] <= '{1'b1, w, io, a, d};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (!grant_out[i] && n < 50);
    if (!grant_out[i]) check("grant", 24'h1, 24'h0);
    ir = int_req_out;
    req_in[i].valid <= 1'b0;
    while (ext && !rsp_out[i].done && n < 300) begin
      @(posedge clk_sys_in);
      n++;
      // Keep the first beat's address only
      if (!io_space_select_n_out && s[1]) io_addr = ext_addr_out;
      s &= {bank_select_n_out, io_space_select_n_out, boot_space_select_n_out};
    end
    rd = rsp_out[i].rdata;
    if (ext && !rsp_out[i].done) check("done", 24'h1, 24'h0);
  endtask : access
  task automatic summarize();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  // ==========================================================
  // Tests
  initial begin
    logic [23:0] v, a;
    logic [5:0]  s;
    int_req_s    ir;
    int          n;
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    reg_rd(REG_BANK_BND, v);
    check("bounds", 24'h008040, v);
    reg_rd(REG_BANK_WAIT, v);
    check("waits", 24'h00FFFF, v);
    reg_rd(4'hA, v);
    check("unmapped", 24'h0, v);
    reg_wr(REG_BANK_WAIT, 16'h0000);
    foreach (pg[i]) begin
      a = {pg[i], 8'h00, 8'(4 * i)};
      access(0, 1'b1, 1'b0, a, 24'h00C300 + 24'(i), 1'b1, v, s, ir);
      check("bank", {18'h0, ~(4'h1 << (i / 2)), 2'b11}, {18'h0, s});
      access(0, 1'b0, 1'b0, a, 24'h0, 1'b1, v, s, ir);
      check("rdata8", 24'h00C300 + 24'(i), {8'h00, v[15:0]});
    end
    reg_wr(REG_BANK_BND, 16'h9020);
    access(0, 1'b0, 1'b0, 24'h300040, 24'h0, 1'b1, v, s, ir);
    check("newbound", 24'h000037, {18'h0, s});
    reg_wr(REG_PORT_CFG, 16'h0003);
    wide <= 1'b1;
    access(1, 1'b1, 1'b0, 24'h050080, 24'h5A3C96, 1'b1, v, s, ir);
    access(2, 1'b0, 1'b0, 24'h050080, 24'h0, 1'b1, v, s, ir);
    check("rdata24", 24'h5A3C96, v);
    check("flag16", 24'h0, {16'h0, flag_in_out});
    reg_wr(REG_PORT_CFG, 16'h0001);
    access(1, 1'b1, 1'b0, 24'h0700A0, 24'h00BEEF, 1'b1, v, s, ir);
    access(1, 1'b0, 1'b0, 24'h0700A0, 24'h0, 1'b1, v, s, ir);
    check("rdata16", 24'h00BEEF, v);
    reg_wr(REG_PORT_CFG, 16'h0002);
    wide <= 1'b0;
    access(2, 1'b1, 1'b0, 24'h060090, 24'h123456, 1'b1, v, s, ir);
    access(2, 1'b0, 1'b0, 24'h060090, 24'h0, 1'b1, v, s, ir);
    check("rdata24n", 24'h123456, v);
    reg_wr(REG_PORT_CFG, 16'h0000);
    io_page_value_in <= 8'h22;
    access(1, 1'b1, 1'b0 | 1'b1, 24'h004155, 24'h000077, 1'b1, v, s, ir);
    check("iosel", 24'h00003D, {18'h0, s});
    check("ioaddr", {6'h0, 8'h22, 10'h155}, {6'h0, io_addr[17:0]});
    access(1, 1'b0, 1'b1, 24'h000C00, 24'h0, 1'b0, v, s, ir);
    check("iocfg", 24'h1, {23'h0, ir.iocfg});
    access(2, 1'b1, 1'b0, 24'h001234, 24'h0000AB, 1'b0, v, s, ir);
    check("sram", 24'h011234, {7'h0, ir.sram, ir.addr});
    access(0, 1'b0, 1'b0, 24'hFF03FF, 24'h0, 1'b0, v, s, ir);
    check("rom", 24'h1, {23'h0, ir.rom});
    boot_ext_in <= 1'b1;
    access(0, 1'b0, 1'b0, 24'hFF0010, 24'h0, 1'b1, v, s, ir);
    check("bootsel", 24'h00003E, {18'h0, s});
    boot_ext_in <= 1'b0;
    access(0, 1'b0, 1'b0, 24'hFF0800, 24'h0, 1'b1, v, s, ir);
    check("bootsel_hi", 24'h00003E, {18'h0, s});
    @(posedge clk_sys_in);
    for (int k = 0; k < NUM_REQ; k++) req_in[k] <= '{1'b1, 1'b0, 1'b0, 24'h000100, 24'h0};
    for (int k = 0; k < NUM_REQ; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys_in);
        n++;
      end while (grant_out == 3'b000 && n < 20);
      check("grant", 24'(1 << k), {21'h0, grant_out});
      req_in[k].valid <= 1'b0;
    end
    repeat (3) @(posedge clk_sys_in);
    check("flag8", 24'h0000A5, {16'h0, flag_in_out});
    reg_rd(REG_FLAG_IN, v);
    check("flagreg", 24'h0000A5, v);
    reg_wr(REG_FLAG_OUT, 16'hC05A);
    reg_wr(REG_FLAG_OE, 16'h00FF);
    repeat (3) @(posedge clk_sys_in);
    check("flagout", 24'h00FF5A, {ext_data_oe_out[15:8], ext_data_out[15:8]});
    check("flagloop", 24'h00005A, {16'h0, flag_in_out});
    summarize();
  end
  // Whole run needs well under 3000 cycles
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule : tb_top
